// ---- core/cwd_pkg.sv ----
// shared constants, register layout and carrier types for the clock watchdog block
package cwd_pkg;

	// reference clock
	localparam int CLK_FREQ_HZ = 200_000_000;

	// watchdog prescaler units
	localparam int SHORT_UNIT_MS = 150;
	localparam int LONG_UNIT_MS = 2500;
	localparam int SHORT_UNIT_CYCLES = (CLK_FREQ_HZ / 1000) * SHORT_UNIT_MS;
	localparam int LONG_UNIT_CYCLES = (CLK_FREQ_HZ / 1000) * LONG_UNIT_MS;

	// system reset pulse width
	localparam int RST_PULSE_US = 20;
	localparam int RST_PULSE_CYCLES = (CLK_FREQ_HZ / 1_000_000) * RST_PULSE_US;
	localparam int RST_CNT_W = 12;

	// field widths
	localparam int TO_W = 5;
	localparam int SEL_W = 5;
	localparam int N_W = 8;
	localparam int M_W = 7;

	// offset added to both N and M in the frequency equation
	localparam logic [8:0] NM_OFFSET = 9'h003;

	// control byte indices on the management bus
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_SEL = 8'h01;
	localparam logic [7:0] IDX_CPU_N = 8'h02;
	localparam logic [7:0] IDX_CPU_M = 8'h03;
	localparam logic [7:0] IDX_REC_N = 8'h04;
	localparam logic [7:0] IDX_REC_M = 8'h05;
	localparam logic [7:0] IDX_WD_VALUE = 8'h06;
	localparam logic [7:0] IDX_STATUS = 8'h07;

	// bit positions inside the control byte
	localparam int CTRL_PROG_EN = 0;
	localparam int CTRL_FS_OVERRIDE = 1;
	localparam int CTRL_WD_ARM = 2;
	localparam int CTRL_TICK_SCALE = 3;
	localparam int CTRL_RST_TO_EN = 4;
	localparam int CTRL_RST_FC_EN = 5;
	localparam int CTRL_REC_SRC = 6;
	localparam int CTRL_TO_FLAG = 7;

	// bit positions inside the status byte
	localparam int STAT_RECOVERY = 5;
	localparam int STAT_TO_FLAG = 6;
	localparam int STAT_RUNNING = 7;

	// values after reset
	localparam logic [TO_W-1:0] WD_VALUE_RST = 5'h00;
	localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
	localparam logic [N_W-1:0] N_RST = 8'h00;
	localparam logic [M_W-1:0] M_RST = 7'h00;

	// serial bus; the address value is arbitrary
	localparam logic [6:0] SMB_ADDR_DEFAULT = 7'h2A;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef struct packed {
		logic prog;
		logic [SEL_W-1:0] gear_sel;
		logic [8:0] num;
		logic [7:0] den;
	} cwd_freq_t;

	typedef struct packed {
		logic valid;
		logic [7:0] index;
		logic [7:0] data;
	} cwd_wr_t;

	typedef enum logic [3:0] {
		BUS_IDLE = 4'b0000,
		BUS_ADDR = 4'b0001,
		BUS_ACK_A = 4'b0010,
		BUS_CMD = 4'b0011,
		BUS_ACK_C = 4'b0100,
		BUS_WDATA = 4'b0101,
		BUS_ACK_W = 4'b0110,
		BUS_RDATA = 4'b0111,
		BUS_RACK = 4'b1000,
		BUS_RNEXT = 4'b1001
	} cwd_bus_state_t;

endpackage

// ---- core/cwd_unit_tick.sv ----
// prescaler that turns the reference clock into watchdog unit ticks
`timescale 1ns/1ps
module cwd_unit_tick #(
	parameter int SHORT_CYCLES = cwd_pkg::SHORT_UNIT_CYCLES,
	parameter int LONG_CYCLES = cwd_pkg::LONG_UNIT_CYCLES
) (
	input wire logic clk_i, // reference clock
	input wire logic resetn_i, // async reset, active low
	input wire logic run_i, // count while high
	input wire logic restart_i, // restart the current unit
	input wire logic long_i, // 1 selects the long unit
	output logic tick_o // one-cycle pulse per unit
);
	import cwd_pkg::*;

	logic [31:0] cnt_reg;
	logic [31:0] limit;

	assign limit = long_i ? 32'(LONG_CYCLES - 1) : 32'(SHORT_CYCLES - 1);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_reg <= 32'h0000_0000;
			tick_o <= 1'b0;
		end
		else if (!run_i || restart_i)
		begin
			cnt_reg <= 32'h0000_0000;
			tick_o <= 1'b0;
		end
		// >= keeps a scale change mid-unit from overrunning the limit
		else if (cnt_reg >= limit)
		begin
			cnt_reg <= 32'h0000_0000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end

endmodule

// ---- core/cwd_smbus_slave.sv ----
// management bus slave: byte writes and reads with auto-incrementing index
`timescale 1ns/1ps
module cwd_smbus_slave #(
	parameter logic [6:0] DEV_ADDR = cwd_pkg::SMB_ADDR_DEFAULT
) (
	input wire logic clk_i, // reference clock
	input wire logic resetn_i, // async reset, active low
	input wire logic scl_i, // bus clock level
	input wire logic sda_i, // bus data level
	input wire logic [7:0] rd_data_i, // byte at rd_index_o
	output logic [7:0] rd_index_o, // current byte index
	output cwd_pkg::cwd_wr_t wr_o, // one-cycle write request
	output logic stop_o, // one-cycle pulse on stop
	output logic sda_oe_n_o // low pulls data low
);
	import cwd_pkg::*;

	cwd_bus_state_t state_reg;
	logic scl_q;
	logic sda_q;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] index_reg;
	logic rw_reg;
	logic start_cond;
	logic stop_cond;
	logic scl_rise;
	logic scl_fall;

	assign start_cond = scl_i && scl_q && sda_q && !sda_i;
	assign stop_cond = scl_i && scl_q && !sda_q && sda_i;
	assign scl_rise = scl_i && !scl_q;
	assign scl_fall = !scl_i && scl_q;
	assign rd_index_o = index_reg;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= BUS_IDLE;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			index_reg <= 8'h00;
			rw_reg <= 1'b0;
			wr_o <= '0;
			stop_o <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end
		else
		begin
			wr_o.valid <= 1'b0;
			stop_o <= 1'b0;
			if (start_cond)
			begin
				state_reg <= BUS_ADDR;
				bit_cnt_reg <= 4'h0;
				sda_oe_n_o <= 1'b1;
			end
			else if (stop_cond)
			begin
				state_reg <= BUS_IDLE;
				sda_oe_n_o <= 1'b1;
				stop_o <= 1'b1;
			end
			else
			begin
				case (state_reg)
					BUS_ADDR, BUS_CMD, BUS_WDATA:
					begin
						if (scl_rise)
						begin
							shift_reg <= {shift_reg[6:0], sda_i};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE)
						begin
							bit_cnt_reg <= 4'h0;
							if (state_reg == BUS_ADDR)
							begin
								if (shift_reg[7:1] == DEV_ADDR)
								begin
									sda_oe_n_o <= 1'b0;
									rw_reg <= shift_reg[0];
									state_reg <= BUS_ACK_A;
								end
								else
								begin
									state_reg <= BUS_IDLE;
								end
							end
							else if (state_reg == BUS_CMD)
							begin
								sda_oe_n_o <= 1'b0;
								state_reg <= BUS_ACK_C;
							end
							else
							begin
								sda_oe_n_o <= 1'b0;
								wr_o <= {1'b1, index_reg, shift_reg};
								state_reg <= BUS_ACK_W;
							end
						end
					end
					BUS_ACK_A:
					begin
						if (scl_fall && rw_reg)
						begin
							shift_reg <= rd_data_i;
							sda_oe_n_o <= rd_data_i[7];
							state_reg <= BUS_RDATA;
						end
						else if (scl_fall)
						begin
							sda_oe_n_o <= 1'b1;
							state_reg <= BUS_CMD;
						end
					end
					BUS_ACK_C:
					begin
						if (scl_fall)
						begin
							sda_oe_n_o <= 1'b1;
							index_reg <= shift_reg;
							state_reg <= BUS_WDATA;
						end
					end
					BUS_ACK_W:
					begin
						if (scl_fall)
						begin
							sda_oe_n_o <= 1'b1;
							index_reg <= index_reg + 8'h01;
							state_reg <= BUS_WDATA;
						end
					end
					BUS_RDATA:
					begin
						if (scl_rise)
						begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
						else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE)
						begin
							sda_oe_n_o <= 1'b1;
							bit_cnt_reg <= 4'h0;
							state_reg <= BUS_RACK;
						end
						else if (scl_fall)
						begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							sda_oe_n_o <= shift_reg[6];
						end
					end
					BUS_RACK:
					begin
						// a not-acknowledge ends the read; the master then stops
						if (scl_rise && sda_i)
						begin
							state_reg <= BUS_IDLE;
						end
						else if (scl_rise)
						begin
							index_reg <= index_reg + 8'h01;
							state_reg <= BUS_RNEXT;
						end
					end
					BUS_RNEXT:
					begin
						if (scl_fall)
						begin
							shift_reg <= rd_data_i;
							sda_oe_n_o <= rd_data_i[7];
							state_reg <= BUS_RDATA;
						end
					end
					default:
					begin
						state_reg <= BUS_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// ---- core/cwd_top.sv ----
// clock generator control: frequency programming, watchdog and recovery
`timescale 1ns/1ps
// Behaviour
// - five-bit watchdog time-out value in units
// - tick scale bit picks 150 ms or 2.5 s
// - time-out spans 1 to 31 units
// - count reaching zero sets time-out flag
// - expiry reset pulse only when enabled
// - frequency-change reset pulse only when enabled
// - programmed output is gear times (N+3)/(M+3)
// - gear from latched straps or programmed select
// - frequency change while armed starts countdown; disarm stops, reloads, unlocks
// - recovery mode ignores frequency writes until disarm
// - flag reads status; write one clears
// - expiry switches to straps or recovery N/M
module cwd_top #(
	parameter int TICK_SHORT_CYCLES = cwd_pkg::SHORT_UNIT_CYCLES,
	parameter int TICK_LONG_CYCLES = cwd_pkg::LONG_UNIT_CYCLES,
	parameter logic [6:0] DEV_ADDR = cwd_pkg::SMB_ADDR_DEFAULT
) (
	input wire logic CLK_I, // reference clock, 200 MHz
	input wire logic RESETN_I, // power-on reset, async, active low
	input wire logic SCL_I, // management bus clock
	input wire logic SDA_I, // management bus data in
	output logic SDA_O, // management bus data out, always low
	output logic SDA_OE_N_O, // low while pulling data low
	input wire logic [cwd_pkg::SEL_W-1:0] STRAP_FREQ_PINS_I, // power-on frequency straps
	output logic RST_O, // system reset pin value, always low
	output logic RST_OE_N_O, // low while the system reset is asserted
	output cwd_pkg::cwd_freq_t FREQ_O, // active frequency setting
	output logic FREQ_LOAD_O, // pulse when FREQ_O takes a new value
	output logic RECOVERY_O, // recovery mode active
	output logic TIMEOUT_FLAG_O // watchdog time-out status
);
	import cwd_pkg::*;

	// bus side
	cwd_wr_t bus_wr;
	logic bus_stop;
	logic [7:0] bus_rd_index;
	logic [7:0] bus_rd_data;

	// software registers
	logic prog_en_reg;
	logic fs_override_reg;
	logic watchdog_arm_reg;
	logic watchdog_tick_scale_reg;
	logic reset_on_timeout_enable_reg;
	logic reset_on_freq_change_enable_reg;
	logic recovery_source_choice_reg;
	logic timeout_flag_reg;
	logic [SEL_W-1:0] sel_reg;
	logic [N_W-1:0] cpu_n_reg;
	logic [M_W-1:0] cpu_m_reg;
	logic [N_W-1:0] recovery_multiplier_reg;
	logic [M_W-1:0] recovery_divider_reg;
	logic [TO_W-1:0] watchdog_timeout_value_reg;

	// strap capture
	logic [SEL_W-1:0] strap_frequency_pins_reg;
	logic strap_taken_reg;
	logic strap_apply_reg;

	// watchdog
	logic wd_running_reg;
	logic [TO_W-1:0] wd_count_reg;
	logic recovery_reg;
	logic [TO_W-1:0] wd_load_val;
	logic unit_tick;
	logic wd_expire;
	logic wd_load;

	// frequency change and outputs
	logic freq_dirty_reg;
	logic freq_change;
	logic apply_now;
	logic apply_reg;
	logic rst_trigger;
	logic [RST_CNT_W-1:0] rst_cnt_reg;
	cwd_freq_t freq_next;

	// select, N and M bytes; control writes change the frequency through the program and override bits
	function automatic logic is_freq_index(input logic [7:0] idx);
		is_freq_index = (idx == IDX_SEL) || (idx == IDX_CPU_N) || (idx == IDX_CPU_M);
	endfunction

	cwd_smbus_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_bus (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.scl_i(SCL_I),
		.sda_i(SDA_I),
		.rd_data_i(bus_rd_data),
		.rd_index_o(bus_rd_index),
		.wr_o(bus_wr),
		.stop_o(bus_stop),
		.sda_oe_n_o(SDA_OE_N_O)
	);

	cwd_unit_tick #(
		.SHORT_CYCLES(TICK_SHORT_CYCLES),
		.LONG_CYCLES(TICK_LONG_CYCLES)
	) u_tick (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.run_i(wd_running_reg),
		.restart_i(wd_load),
		.long_i(watchdog_tick_scale_reg),
		.tick_o(unit_tick)
	);

	// straps are sampled on the first edge after reset release, never by the reset itself
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			strap_frequency_pins_reg <= SEL_RST;
			strap_taken_reg <= 1'b0;
			strap_apply_reg <= 1'b0;
		end
		else
		begin
			strap_apply_reg <= !strap_taken_reg;
			if (!strap_taken_reg)
			begin
				strap_frequency_pins_reg <= STRAP_FREQ_PINS_I;
				strap_taken_reg <= 1'b1;
			end
		end
	end

	// control and value registers
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			prog_en_reg <= 1'b0;
			fs_override_reg <= 1'b0;
			watchdog_arm_reg <= 1'b0;
			watchdog_tick_scale_reg <= 1'b0;
			reset_on_timeout_enable_reg <= 1'b0;
			reset_on_freq_change_enable_reg <= 1'b0;
			recovery_source_choice_reg <= 1'b0;
			sel_reg <= SEL_RST;
			cpu_n_reg <= N_RST;
			cpu_m_reg <= M_RST;
			recovery_multiplier_reg <= N_RST;
			recovery_divider_reg <= M_RST;
			watchdog_timeout_value_reg <= WD_VALUE_RST;
		end
		else if (bus_wr.valid)
		begin
			if (bus_wr.index == IDX_CTRL)
			begin
				if (!recovery_reg)
				begin
					prog_en_reg <= bus_wr.data[CTRL_PROG_EN];
					fs_override_reg <= bus_wr.data[CTRL_FS_OVERRIDE];
				end
				watchdog_arm_reg <= bus_wr.data[CTRL_WD_ARM];
				watchdog_tick_scale_reg <= bus_wr.data[CTRL_TICK_SCALE];
				reset_on_timeout_enable_reg <= bus_wr.data[CTRL_RST_TO_EN];
				reset_on_freq_change_enable_reg <= bus_wr.data[CTRL_RST_FC_EN];
				recovery_source_choice_reg <= bus_wr.data[CTRL_REC_SRC];
			end
			else if (is_freq_index(bus_wr.index) && recovery_reg)
			begin
				// locked out while recovering
			end
			else if (bus_wr.index == IDX_SEL)
			begin
				sel_reg <= bus_wr.data[SEL_W-1:0];
			end
			else if (bus_wr.index == IDX_CPU_N)
			begin
				cpu_n_reg <= bus_wr.data;
			end
			else if (bus_wr.index == IDX_CPU_M)
			begin
				cpu_m_reg <= bus_wr.data[M_W-1:0];
			end
			else if (bus_wr.index == IDX_REC_N)
			begin
				recovery_multiplier_reg <= bus_wr.data;
			end
			else if (bus_wr.index == IDX_REC_M)
			begin
				recovery_divider_reg <= bus_wr.data[M_W-1:0];
			end
			else if (bus_wr.index == IDX_WD_VALUE)
			begin
				watchdog_timeout_value_reg <= bus_wr.data[TO_W-1:0];
			end
		end
	end

	// read mux; unmapped indices and unused bits read as zero
	always_comb
	begin
		bus_rd_data = 8'h00;
		if (bus_rd_index == IDX_CTRL)
		begin
			bus_rd_data[CTRL_PROG_EN] = prog_en_reg;
			bus_rd_data[CTRL_FS_OVERRIDE] = fs_override_reg;
			bus_rd_data[CTRL_WD_ARM] = watchdog_arm_reg;
			bus_rd_data[CTRL_TICK_SCALE] = watchdog_tick_scale_reg;
			bus_rd_data[CTRL_RST_TO_EN] = reset_on_timeout_enable_reg;
			bus_rd_data[CTRL_RST_FC_EN] = reset_on_freq_change_enable_reg;
			bus_rd_data[CTRL_REC_SRC] = recovery_source_choice_reg;
			bus_rd_data[CTRL_TO_FLAG] = timeout_flag_reg;
		end
		else if (bus_rd_index == IDX_SEL)
		begin
			bus_rd_data[SEL_W-1:0] = sel_reg;
		end
		else if (bus_rd_index == IDX_CPU_N)
		begin
			bus_rd_data = cpu_n_reg;
		end
		else if (bus_rd_index == IDX_CPU_M)
		begin
			bus_rd_data[M_W-1:0] = cpu_m_reg;
		end
		else if (bus_rd_index == IDX_REC_N)
		begin
			bus_rd_data = recovery_multiplier_reg;
		end
		else if (bus_rd_index == IDX_REC_M)
		begin
			bus_rd_data[M_W-1:0] = recovery_divider_reg;
		end
		else if (bus_rd_index == IDX_WD_VALUE)
		begin
			bus_rd_data[TO_W-1:0] = watchdog_timeout_value_reg;
		end
		else if (bus_rd_index == IDX_STATUS)
		begin
			bus_rd_data[TO_W-1:0] = wd_count_reg;
			bus_rd_data[STAT_RECOVERY] = recovery_reg;
			bus_rd_data[STAT_TO_FLAG] = timeout_flag_reg;
			bus_rd_data[STAT_RUNNING] = wd_running_reg;
		end
	end

	// a word or block write updates N and M together, so the change takes effect at stop
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			freq_dirty_reg <= 1'b0;
		end
		else if (bus_stop)
		begin
			freq_dirty_reg <= 1'b0;
		end
		else if (bus_wr.valid && !recovery_reg)
		begin
			if (is_freq_index(bus_wr.index))
			begin
				freq_dirty_reg <= 1'b1;
			end
			else if (bus_wr.index == IDX_CTRL
				&& (bus_wr.data[CTRL_PROG_EN] != prog_en_reg
				|| bus_wr.data[CTRL_FS_OVERRIDE] != fs_override_reg))
			begin
				freq_dirty_reg <= 1'b1;
			end
		end
	end

	assign freq_change = bus_stop && freq_dirty_reg && !recovery_reg;

	// watchdog countdown
	assign wd_load_val = (watchdog_timeout_value_reg == '0) ? 5'h01 : watchdog_timeout_value_reg;
	assign wd_load = watchdog_arm_reg && !recovery_reg && freq_change;
	assign wd_expire = wd_running_reg && unit_tick && (wd_count_reg == 5'h01);

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			wd_running_reg <= 1'b0;
			wd_count_reg <= WD_VALUE_RST;
			recovery_reg <= 1'b0;
		end
		else if (!watchdog_arm_reg)
		begin
			wd_running_reg <= 1'b0;
			wd_count_reg <= wd_load_val;
			recovery_reg <= 1'b0;
		end
		else if (wd_expire)
		begin
			wd_running_reg <= 1'b0;
			wd_count_reg <= '0;
			recovery_reg <= 1'b1;
		end
		else if (wd_load)
		begin
			wd_running_reg <= 1'b1;
			wd_count_reg <= wd_load_val;
		end
		else if (wd_running_reg && unit_tick)
		begin
			wd_count_reg <= wd_count_reg - 5'h01;
		end
	end

	// expiry sets the flag even in the cycle software writes one to clear it
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			timeout_flag_reg <= 1'b0;
		end
		else if (wd_expire)
		begin
			timeout_flag_reg <= 1'b1;
		end
		else if (bus_wr.valid && bus_wr.index == IDX_CTRL && bus_wr.data[CTRL_TO_FLAG])
		begin
			timeout_flag_reg <= 1'b0;
		end
	end

	// frequency selection
	always_comb
	begin
		freq_next.gear_sel = fs_override_reg ? sel_reg : strap_frequency_pins_reg;
		freq_next.prog = prog_en_reg;
		freq_next.num = {1'b0, cpu_n_reg} + NM_OFFSET;
		freq_next.den = 8'({1'b0, cpu_m_reg} + NM_OFFSET);
		if (recovery_reg && !recovery_source_choice_reg)
		begin
			freq_next.prog = 1'b0;
			freq_next.gear_sel = strap_frequency_pins_reg;
		end
		else if (recovery_reg)
		begin
			freq_next.prog = 1'b1;
			freq_next.num = {1'b0, recovery_multiplier_reg} + NM_OFFSET;
			freq_next.den = 8'({1'b0, recovery_divider_reg} + NM_OFFSET);
		end
	end

	// applied one cycle after the cause so recovery state has already settled
	assign apply_now = strap_apply_reg || freq_change || wd_expire
		|| (recovery_reg && !watchdog_arm_reg);

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			apply_reg <= 1'b0;
			FREQ_O <= '0;
			FREQ_LOAD_O <= 1'b0;
		end
		else
		begin
			apply_reg <= apply_now;
			FREQ_LOAD_O <= apply_reg;
			if (apply_reg)
			begin
				FREQ_O <= freq_next;
			end
		end
	end

	// system reset pulse, open drain
	assign rst_trigger = (wd_expire && reset_on_timeout_enable_reg)
		|| (freq_change && reset_on_freq_change_enable_reg);

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			rst_cnt_reg <= '0;
			RST_OE_N_O <= 1'b1;
		end
		else if (rst_trigger)
		begin
			rst_cnt_reg <= RST_CNT_W'(RST_PULSE_CYCLES - 1);
			RST_OE_N_O <= 1'b0;
		end
		else if (rst_cnt_reg != '0)
		begin
			rst_cnt_reg <= rst_cnt_reg - 12'h001;
		end
		else
		begin
			RST_OE_N_O <= 1'b1;
		end
	end

	// the pins only ever pull low; constant drive values still come from flops
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			SDA_O <= 1'b0;
			RST_O <= 1'b0;
			RECOVERY_O <= 1'b0;
			TIMEOUT_FLAG_O <= 1'b0;
		end
		else
		begin
			SDA_O <= 1'b0;
			RST_O <= 1'b0;
			RECOVERY_O <= recovery_reg;
			TIMEOUT_FLAG_O <= timeout_flag_reg;
		end
	end

endmodule

// ---- tb/cwd_monitor.sv ----
// concurrent checks on the clock watchdog top ports
`timescale 1ns/1ps
module cwd_monitor (
	input wire logic CLK_I, // reference clock
	input wire logic RESETN_I, // async reset, active low
	input wire logic [cwd_pkg::SEL_W-1:0] STRAP_FREQ_PINS_I, // straps
	input wire logic RST_O, // reset pin value
	input wire logic RST_OE_N_O, // reset asserted while low
	input wire cwd_pkg::cwd_freq_t FREQ_O, // active setting
	input wire logic FREQ_LOAD_O, // new setting pulse
	input wire logic RECOVERY_O, // recovery mode
	input wire logic TIMEOUT_FLAG_O // time-out flag
);
	import cwd_pkg::*;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	logic [RST_CNT_W-1:0] low_cnt_reg;
	// width of the reset pulse, judged when it ends
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			low_cnt_reg <= '0;
		else
			low_cnt_reg <= RST_OE_N_O ? '0 : low_cnt_reg + 1'b1;
	end
	sequence strap_load;
		FREQ_LOAD_O && !FREQ_O.prog && FREQ_O.gear_sel == STRAP_FREQ_PINS_I;
	endsequence
	sequence held_recovery;
		RECOVERY_O [*4];
	endsequence
	chk_strap_start: assert property ($rose(RESETN_I) |-> ##[2:4] strap_load)
		else $error("strap setting not applied after reset");
	chk_pulse_width: assert property ($rose(RST_OE_N_O) |-> low_cnt_reg == RST_PULSE_CYCLES)
		else $error("system reset pulse has wrong width");
	chk_pin_level: assert property ($fell(RST_OE_N_O) |=>
		FREQ_LOAD_O && RST_O == 1'b0)
		else $error("reset pulse without setting change");
	chk_freq_hold: assert property (!FREQ_LOAD_O |-> $stable(FREQ_O))
		else $error("setting changed without load pulse");
	chk_load_single: assert property (FREQ_LOAD_O |=> !FREQ_LOAD_O)
		else $error("load pulse longer than one cycle");
	chk_prog_terms: assert property (FREQ_LOAD_O && FREQ_O.prog |->
		FREQ_O.num >= 9'h003 && FREQ_O.den inside {[8'h03:8'h82]})
		else $error("programmed terms lack offset");
	chk_flag_recov: assert property ($rose(TIMEOUT_FLAG_O) |-> RECOVERY_O)
		else $error("flag set without recovery");
	chk_lock_hold: assert property (held_recovery |-> !FREQ_LOAD_O)
		else $error("setting loaded while locked");
	chk_recov_switch: assert property ($rose(RECOVERY_O) |-> ##[0:3] FREQ_LOAD_O)
		else $error("no recovery setting applied");
endmodule
bind cwd_top cwd_monitor i_cwd_monitor (
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .STRAP_FREQ_PINS_I(STRAP_FREQ_PINS_I),
	.RST_O(RST_O), .RST_OE_N_O(RST_OE_N_O), .FREQ_O(FREQ_O), .FREQ_LOAD_O(FREQ_LOAD_O),
	.RECOVERY_O(RECOVERY_O), .TIMEOUT_FLAG_O(TIMEOUT_FLAG_O)
);

// ---- tb/cwd_host.sv ----
// management bus host model with pulled-up data line
`timescale 1ns/1ps
module cwd_host (
	input wire logic clk_i, // reference clock
	input wire logic dev_oe_n_i, // device pulls data low while 0
	output logic scl_o, // bus clock
	output logic sda_o // resolved data line
);
	logic drv_reg;
	// open drain: either side pulling low wins
	assign sda_o = drv_reg & dev_oe_n_i;
	initial
	begin
		scl_o = 1'b1;
		drv_reg = 1'b1;
	end
	task automatic half();
		repeat (8) @(negedge clk_i);
	endtask
	task automatic start();
		drv_reg = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		drv_reg = 1'b0;
		half();
		scl_o = 1'b0;
	endtask
	task automatic stop();
		drv_reg = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		drv_reg = 1'b1;
		half();
	endtask
	// eight data bits then the acknowledge bit, msb first
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		logic [8:0] sh;
		logic [8:0] r;
		sh = {d, ack_in};
		for (int i = 8; i >= 0; i--)
		begin
			half();
			drv_reg = sh[i];
			half();
			scl_o = 1'b1;
			half();
			r[i] = sda_o;
			scl_o = 1'b0;
		end
		q = r[8:1];
		ack = r[0];
	endtask
endmodule

// ---- tb/cwd_top_tb_top.sv ----
// self-checking bench for the clock watchdog block
`timescale 1ns/1ps
module cwd_top_tb_top;
	import cwd_pkg::*;
	localparam logic [4:0] STRAPS = 5'h0B;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic scl;
	logic sda;
	logic sda_o;
	logic sda_oe_n;
	logic rst_o;
	logic rst_oe_n;
	cwd_freq_t freq;
	logic load;
	logic recov;
	logic flag;
	logic [7:0] rd;
	logic [4:0] straps = STRAPS;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int k;
	cwd_top #(.TICK_SHORT_CYCLES(20), .TICK_LONG_CYCLES(50)) i_cwd_top (
		.CLK_I(clk), .RESETN_I(resetn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
		.SDA_OE_N_O(sda_oe_n), .STRAP_FREQ_PINS_I(straps), .RST_O(rst_o),
		.RST_OE_N_O(rst_oe_n), .FREQ_O(freq), .FREQ_LOAD_O(load),
		.RECOVERY_O(recov), .TIMEOUT_FLAG_O(flag)
	);
	cwd_host i_host (.clk_i(clk), .dev_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
	always #2.5 clk = ~clk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			mismatches++;
			$display("BAD %0t run too long", $time);
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic put(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		i_host.xfer(d, 1'b1, q, a);
		chk(a, 1'b0, "byte not acknowledged");
	endtask
	task automatic wr1(input logic [7:0] idx, input logic [7:0] d);
		i_host.start();
		put({SMB_ADDR_DEFAULT, 1'b0});
		put(idx);
		put(d);
		i_host.stop();
	endtask
	task automatic wr3(input logic [7:0] idx, input logic [23:0] d);
		i_host.start();
		put({SMB_ADDR_DEFAULT, 1'b0});
		put(idx);
		put(d[23:16]);
		put(d[15:8]);
		put(d[7:0]);
		i_host.stop();
	endtask
	task automatic rd_status(input logic [7:0] idx, output logic [7:0] q);
		logic a;
		i_host.start();
		put({SMB_ADDR_DEFAULT, 1'b0});
		put(idx);
		i_host.start();
		put({SMB_ADDR_DEFAULT, 1'b1});
		i_host.xfer(8'hFF, 1'b1, q, a);
		i_host.stop();
	endtask
	task automatic wait_rst_end();
		for (k = 0; k < 5000 && rst_oe_n !== 1'b1; k++)
			@(negedge clk);
		chk(rst_oe_n, 1'b1, "reset pulse never ended");
	endtask
	initial
	begin
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (6) @(negedge clk);
		chk({freq.prog, freq.gear_sel}, {1'b0, STRAPS}, "strap setting");
		chk({sda_o, rst_o}, 2'b00, "pin drive level");
		// straps move after capture; only the latched value may be used later
		straps = 5'h14;
		$display("end of strap test");
		wr3(IDX_SEL, 24'h13_615D);
		chk(rst_oe_n, 1'b1, "reset pulse while disabled");
		wr1(IDX_CTRL, 8'h23);
		chk(freq, {1'b1, 5'h13, 9'h064, 8'h60}, "programmed setting");
		chk(rst_oe_n, 1'b0, "no reset on change");
		wait_rst_end();
		$display("end of program test");
		wr3(IDX_REC_N, 24'h0A_0502);
		wr1(IDX_CTRL, 8'h57);
		wr1(IDX_CPU_N, 8'h61);
		chk(flag, 1'b0, "early expiry");
		for (k = 0; k < 100 && flag !== 1'b1; k++)
			@(negedge clk);
		chk(k >= 26 && k <= 38, 1'b1, "expiry time");
		chk(flag, 1'b1, "no expiry");
		repeat (3) @(negedge clk);
		chk(recov, 1'b1, "no recovery");
		chk(freq, {1'b1, 5'h13, 9'h00D, 8'h08}, "recovery setting");
		chk(rst_oe_n, 1'b0, "no expiry reset");
		$display("end of expiry test");
		wr1(IDX_CPU_N, 8'hC8);
		chk(freq, {1'b1, 5'h13, 9'h00D, 8'h08}, "write in recovery");
		rd_status(IDX_STATUS, rd);
		chk(rd & 8'h60, 8'h60, "status byte");
		rd_status(IDX_CTRL, rd);
		chk(rd, 8'hD7, "control readback");
		wr1(IDX_CTRL, 8'h57);
		chk(flag, 1'b1, "flag cleared by zero");
		wr1(IDX_CTRL, 8'hD7);
		chk({flag, recov}, 2'b01, "flag clear");
		wr1(IDX_CTRL, 8'h53);
		chk({recov, freq}, {1'b0, 1'b1, 5'h13, 9'h064, 8'h60}, "disarm");
		wait_rst_end();
		$display("end of lock test");
		wr1(IDX_WD_VALUE, 8'h00);
		wr1(IDX_CTRL, 8'h0F);
		wr1(IDX_CPU_N, 8'h61);
		repeat (30) @(negedge clk);
		chk(flag, 1'b0, "long unit too short");
		for (k = 0; k < 100 && flag !== 1'b1; k++)
			@(negedge clk);
		chk(flag, 1'b1, "zero value no expiry");
		repeat (3) @(negedge clk);
		chk({freq.prog, freq.gear_sel}, {1'b0, STRAPS}, "strap recovery");
		chk(rst_oe_n, 1'b1, "reset while disabled");
		$display("end of long scale test");
		wrap_up();
	end
endmodule
